// ### rtl/css_clock_select.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
`include "css_defines.svh"

module css_clock_select (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Fuses and factory signature row
    input  wire logic        fuse_valid_i,
    input  wire logic [3:0]  clock_select_fuses_i,
    input  wire logic [1:0]  startup_time_fuses_i,
    output logic      [7:0]  sig_addr_o,
    input  wire logic [7:0]  sig_data_hi_i,
    // Oscillator side
    input  wire logic        osc_tick_i,
    input  wire logic        wdt_osc_i,
    input  wire logic        wake_i,
    // Clock control outputs
    output logic             use_ext_clk_o,
    output logic             irc_en_o,
    output logic             erc_en_o,
    output logic      [1:0]  band_o,
    output logic      [7:0]  trim_value_o,
    output logic             core_clk_en_o
);
    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection
    logic osc_tick_s;
    logic wdt_osc_s;
    logic wake_s;
    logic osc_tick_d_reg;
    logic wdt_osc_d_reg;
    logic wake_d_reg;

    css_sync u_sync_osc (.clk_i(clk_i), .rst_i(rst_i), .d_i(osc_tick_i), .q_o(osc_tick_s));
    css_sync u_sync_wdt (.clk_i(clk_i), .rst_i(rst_i), .d_i(wdt_osc_i),  .q_o(wdt_osc_s));
    css_sync u_sync_wak (.clk_i(clk_i), .rst_i(rst_i), .d_i(wake_i),     .q_o(wake_s));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_tick_d_reg <= 1'b0;
            wdt_osc_d_reg  <= 1'b0;
            wake_d_reg     <= 1'b0;
        end else begin
            osc_tick_d_reg <= osc_tick_s;
            wdt_osc_d_reg  <= wdt_osc_s;
            wake_d_reg     <= wake_s;
        end
    end

    wire osc_edge  = osc_tick_s & ~osc_tick_d_reg;
    wire wdt_edge  = wdt_osc_s & ~wdt_osc_d_reg;
    wire wake_rise = wake_s & ~wake_d_reg;

    //////////////////////////////////////////////////////////////////////////
    // Fuse decode; without programmed fuses the factory defaults apply
    wire [3:0] sel_fuse = fuse_valid_i ? clock_select_fuses_i : `CSS_DEF_SEL;
    wire [1:0] sut_fuse = fuse_valid_i ? startup_time_fuses_i : `CSS_DEF_SUT;

    wire is_ext = (sel_fuse == `CSS_SEL_EXT_CLK);
    wire is_irc = (sel_fuse >= `CSS_SEL_IRC_LO) && (sel_fuse <= `CSS_SEL_IRC_HI);
    wire is_erc = (sel_fuse >= `CSS_SEL_ERC_LO) && (sel_fuse <= `CSS_SEL_ERC_HI);
    wire sut_bad = !is_erc && (sut_fuse == `CSS_SUT_FAST);
    wire cfg_invalid = !(is_ext || is_irc || is_erc) || sut_bad;

    css_pkg::css_src_t src;
    assign src = cfg_invalid ? css_pkg::CSS_SRC_NONE :
                 is_ext      ? css_pkg::CSS_SRC_EXT  :
                 is_irc      ? css_pkg::CSS_SRC_IRC  : css_pkg::CSS_SRC_ERC;

    // Band index: low to high within the selected source
    wire [3:0] band_raw = is_erc ? (sel_fuse - `CSS_SEL_ERC_LO) : (sel_fuse - `CSS_SEL_IRC_LO);
    wire [1:0] band     = (!cfg_invalid && (is_erc || is_irc)) ? band_raw[1:0] : 2'h0;

    // Start-up cycles: 18 for external RC except fast option, else 6
    wire [4:0] ck_need = (is_erc && sut_fuse != `CSS_SUT_FAST) ? `CSS_CK_LONG
                                                                : `CSS_CK_SHORT;
    // Reset extra delay, in watchdog oscillator cycles
    wire [16:0] wd_need = (sut_fuse == `CSS_SUT_NONE)  ? 17'h00000 :
                          (sut_fuse == `CSS_SUT_LONG)  ? `CSS_WDT_LONG :
                                                         `CSS_WDT_SHORT;

    //////////////////////////////////////////////////////////////////////////
    // Register bus decode
    wire bus_req  = cyc_i & stb_i & ~ack_o;
    wire wr_req   = bus_req & we_i;
    wire hit_trim = (adr_i == `CSS_ADDR_TRIM);
    wire hit_ctrl = (adr_i == `CSS_ADDR_CTRL);
    wire trim_wr  = wr_req & hit_trim & sel_i[0];
    wire restart  = wr_req & hit_ctrl & sel_i[0] & dat_i[`CSS_CTRL_RESTART];

    //////////////////////////////////////////////////////////////////////////
    // Start-up sequencer
    css_pkg::css_state_t state_reg;
    css_pkg::css_state_t state_next;
    logic [4:0]  ck_cnt_reg;
    logic [16:0] wd_cnt_reg;
    logic        cold_reg;
    logic        boot_reg;
    logic [7:0]  trim_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            css_pkg::CSS_ST_GATED: begin
                if (!cfg_invalid)
                    state_next = css_pkg::CSS_ST_CKCOUNT;
            end
            css_pkg::CSS_ST_CKCOUNT: begin
                if (ck_cnt_reg >= ck_need)
                    state_next = (cold_reg && wd_need != 17'h00000) ?
                                 css_pkg::CSS_ST_WDWAIT : css_pkg::CSS_ST_RUNNING;
            end
            css_pkg::CSS_ST_WDWAIT: begin
                if (wd_cnt_reg >= wd_need)
                    state_next = css_pkg::CSS_ST_RUNNING;
            end
            css_pkg::CSS_ST_RUNNING: begin
                if (cfg_invalid)
                    state_next = css_pkg::CSS_ST_GATED;
            end
            default: state_next = css_pkg::CSS_ST_GATED;
        endcase
        // A wake from power-down restarts the oscillator count
        if (wake_rise || restart)
            state_next = css_pkg::CSS_ST_GATED;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= css_pkg::CSS_ST_GATED;
            cold_reg  <= 1'b1;
        end else begin
            state_reg <= state_next;
            if (state_reg == css_pkg::CSS_ST_RUNNING)
                cold_reg <= 1'b0;
        end
    end

    // Counts only oscillator edges, so wake uses the same fuse period
    always_ff @(posedge clk_i) begin
        if (rst_i || state_reg != css_pkg::CSS_ST_CKCOUNT)
            ck_cnt_reg <= 5'h00;
        else if (osc_edge && ck_cnt_reg != 5'h1f)
            ck_cnt_reg <= ck_cnt_reg + 5'h01;
    end

    // Reset delay runs from the watchdog oscillator, not the chip clock
    always_ff @(posedge clk_i) begin
        if (rst_i || state_reg != css_pkg::CSS_ST_WDWAIT)
            wd_cnt_reg <= 17'h00000;
        else if (wdt_edge && wd_cnt_reg != 17'h1ffff)
            wd_cnt_reg <= wd_cnt_reg + 17'h00001;
    end

    //////////////////////////////////////////////////////////////////////////
    // Trim register: factory byte loaded in the first cycle after reset, then software owned
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_reg <= 1'b1;
            trim_reg <= 8'h00;
        end else if (boot_reg) begin
            boot_reg <= 1'b0;
            trim_reg <= sig_data_hi_i;
        end else if (trim_wr) begin
            trim_reg <= dat_i[7:0];
        end
    end

    assign sig_addr_o = `CSS_SIG_TRIM_ADDR;

    //////////////////////////////////////////////////////////////////////////
    // Outputs to the clock tree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            use_ext_clk_o <= 1'b0;
            irc_en_o      <= 1'b0;
            erc_en_o      <= 1'b0;
            band_o        <= 2'h0;
        end else begin
            use_ext_clk_o <= (src == css_pkg::CSS_SRC_EXT);
            irc_en_o      <= (src == css_pkg::CSS_SRC_IRC);
            erc_en_o      <= (src == css_pkg::CSS_SRC_ERC);
            band_o        <= band;
        end
    end

    assign trim_value_o  = trim_reg;
    assign core_clk_en_o = (state_reg == css_pkg::CSS_ST_RUNNING);

    //////////////////////////////////////////////////////////////////////////
    // Read data and acknowledge: one registered answer per request, the cycle after it
    wire [31:0] rd_status = {29'h0,
                             state_reg != css_pkg::CSS_ST_RUNNING &&
                             state_reg != css_pkg::CSS_ST_GATED,
                             cfg_invalid,
                             core_clk_en_o};
    wire [31:0] rd_mux = hit_trim                   ? {24'h0, trim_reg} :
                         (adr_i == `CSS_ADDR_FUSE)  ? {26'h0, sut_fuse, sel_fuse} :
                         (adr_i == `CSS_ADDR_STATUS)? rd_status : 32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= bus_req;
            dat_o <= bus_req ? rd_mux : 32'h0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    gate_until_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(core_clk_en_o) |-> $past(state_reg) != css_pkg::CSS_ST_GATED)
        else $error("core clock released without start-up count");
    invalid_gated_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_invalid |=> !core_clk_en_o)
        else $error("clock released on invalid fuses");
    ext_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (sel_fuse == `CSS_SEL_EXT_CLK && !cfg_invalid) |=> use_ext_clk_o)
        else $error("external clock not selected");
    irc_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_irc && !sut_bad) |=> irc_en_o && !erc_en_o)
        else $error("internal rc not selected");
    erc_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
        is_erc |=> erc_en_o && band_o == $past(band_raw[1:0]))
        else $error("external rc band wrong");
    ck_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == css_pkg::CSS_ST_CKCOUNT && is_erc && sut_fuse != 2'h3
         && ck_cnt_reg < 5'h12) |=> state_reg != css_pkg::CSS_ST_RUNNING)
        else $error("rc start-up shorter than 18 cycles");
    wd_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == css_pkg::CSS_ST_WDWAIT && wd_cnt_reg < wd_need
         && !wake_rise && !restart) |=> !core_clk_en_o)
        else $error("reset delay cut short");
    trim_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        boot_reg |=> trim_value_o == $past(sig_data_hi_i))
        else $error("factory trim not loaded");
    trim_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (trim_wr && !boot_reg) |=> trim_value_o == $past(dat_i[7:0]))
        else $error("trim write lost");
    default_fuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !fuse_valid_i |-> sel_fuse == 4'h1 && sut_fuse == 2'h2)
        else $error("factory defaults not applied");

    // Start-up counting, release, selection and trim read consistency
    onehot_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1
        |-> $onehot0({use_ext_clk_o, irc_en_o, erc_en_o}))
        else $error("more than one clock source selected");
    short_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == css_pkg::CSS_ST_CKCOUNT && !is_erc && ck_cnt_reg >= `CSS_CK_SHORT)
        |=> state_reg != css_pkg::CSS_ST_CKCOUNT)
        else $error("six-cycle start-up not ended");
    long_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == css_pkg::CSS_ST_CKCOUNT && cold_reg && ck_cnt_reg >= ck_need
         && sut_fuse == `CSS_SUT_LONG && !wake_rise && !restart)
        |=> state_reg == css_pkg::CSS_ST_WDWAIT)
        else $error("long reset delay skipped");
    warm_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == css_pkg::CSS_ST_CKCOUNT && !cold_reg && ck_cnt_reg >= ck_need
         && !wake_rise && !restart)
        |=> state_reg == css_pkg::CSS_ST_RUNNING)
        else $error("wake did not release after start-up count");
    restart_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        restart
        |=> !core_clk_en_o)
        else $error("restart left core clock running");
    trim_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_req && !we_i && hit_trim)
        |=> ack_o && dat_o == {24'h0, $past(trim_reg)})
        else $error("trim read data wrong");
endmodule : css_clock_select

// ### rtl/css_defines.svh
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH

// Register map (byte addresses on the bus)
`define CSS_ADDR_TRIM       4'h0
`define CSS_ADDR_FUSE       4'h4
`define CSS_ADDR_STATUS     4'h8
`define CSS_ADDR_CTRL       4'hc

// Clock-select fuse encodings
`define CSS_SEL_EXT_CLK     4'h0
`define CSS_SEL_IRC_LO      4'h1
`define CSS_SEL_IRC_HI      4'h4
`define CSS_SEL_ERC_LO      4'h5
`define CSS_SEL_ERC_HI      4'h8

// Start-up fuse encodings
`define CSS_SUT_NONE        2'h0
`define CSS_SUT_SHORT       2'h1
`define CSS_SUT_LONG        2'h2
`define CSS_SUT_FAST        2'h3

// Factory defaults
`define CSS_DEF_SEL         4'h1
`define CSS_DEF_SUT         2'h2
`define CSS_SIG_TRIM_ADDR   8'h00

// Start-up cycle counts
`define CSS_CK_LONG         5'h12
`define CSS_CK_SHORT        5'h06

// Reset delays in watchdog oscillator cycles
`define CSS_WDT_SHORT       17'h01000
`define CSS_WDT_LONG        17'h10000

// Control and status bit positions
`define CSS_CTRL_RESTART    0
`define CSS_ST_RUN          0
`define CSS_ST_INVALID      1
`define CSS_ST_BUSY         2

`endif

// ### rtl/css_pkg.sv
package css_pkg;
    typedef enum logic [1:0] {
        CSS_SRC_EXT,
        CSS_SRC_IRC,
        CSS_SRC_ERC,
        CSS_SRC_NONE
    } css_src_t;

    typedef enum logic [1:0] {
        CSS_ST_GATED,
        CSS_ST_CKCOUNT,
        CSS_ST_WDWAIT,
        CSS_ST_RUNNING
    } css_state_t;
endpackage : css_pkg

// ### rtl/css_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for pins from outside the clock domain
module css_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Data
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            q_o      <= 1'b0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule : css_sync

// ### tb/css_osc_model.sv
`timescale 1ns/100ps
// Far-side oscillators: the selected clock source and the watchdog oscillator.
// Each one emits exactly as many rising edges as asked, then stands still low.
module css_osc_model (
    // Clock
    input  wire logic        clk_i,
    // Requested edge totals, zero clears the count
    input  wire logic [7:0]  osc_want_i,
    input  wire logic [12:0] wdt_want_i,
    // Oscillator pins
    output logic             osc_o,
    output logic             wdt_o,
    // Edges emitted so far
    output logic      [7:0]  osc_cnt_o,
    output logic      [12:0] wdt_cnt_o
);
    logic [2:0] ph_reg;

    assign osc_o = ph_reg[2];

    // Fixed period of eight system cycles, so no cycle-to-cycle drift
    always_ff @(posedge clk_i) begin
        if (osc_want_i == 8'h00) begin
            ph_reg    <= 3'h0;
            osc_cnt_o <= 8'h00;
        end else if (ph_reg != 3'h0 || osc_cnt_o < osc_want_i) begin
            ph_reg <= ph_reg + 3'h1;
            if (ph_reg == 3'h3) begin
                osc_cnt_o <= osc_cnt_o + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (wdt_want_i == 13'h0000) begin
            wdt_o     <= 1'b0;
            wdt_cnt_o <= 13'h0000;
        end else if (wdt_o || wdt_cnt_o < wdt_want_i) begin
            wdt_o <= ~wdt_o;
            if (!wdt_o) begin
                wdt_cnt_o <= wdt_cnt_o + 13'h0001;
            end
        end
    end
endmodule : css_osc_model

// ### tb/clock_source_startup_select_test.sv
`timescale 1ns/100ps
module clock_source_startup_select_test;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0;
    logic [3:0]  sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0000_0000;
    logic        fuse_valid_i = 1'b0;
    logic [3:0]  clock_select_fuses_i = 4'h0;
    logic [1:0]  startup_time_fuses_i = 2'h0;
    logic [7:0]  sig_data_hi_i = 8'h5a;
    logic        wake_i = 1'b0;
    logic [7:0]  osc_want = 8'h00;
    logic [12:0] wdt_want = 13'h0000;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [7:0]  sig_addr_o;
    logic        osc_tick_i;
    logic        wdt_osc_i;
    logic        use_ext_clk_o;
    logic        irc_en_o;
    logic        erc_en_o;
    logic [1:0]  band_o;
    logic [7:0]  trim_value_o;
    logic        core_clk_en_o;
    logic [7:0]  osc_cnt;
    logic [12:0] wdt_cnt;
    logic [31:0] rd;
    int          bad_count = 0;
    int          compares = 0;

    always #5 clk_i = ~clk_i;

    css_clock_select i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .fuse_valid_i(fuse_valid_i),
        .clock_select_fuses_i(clock_select_fuses_i),
        .startup_time_fuses_i(startup_time_fuses_i), .sig_addr_o(sig_addr_o),
        .sig_data_hi_i(sig_data_hi_i), .osc_tick_i(osc_tick_i), .wdt_osc_i(wdt_osc_i),
        .wake_i(wake_i), .use_ext_clk_o(use_ext_clk_o), .irc_en_o(irc_en_o),
        .erc_en_o(erc_en_o), .band_o(band_o), .trim_value_o(trim_value_o),
        .core_clk_en_o(core_clk_en_o));

    css_osc_model i_osc (.clk_i(clk_i), .osc_want_i(osc_want), .wdt_want_i(wdt_want),
        .osc_o(osc_tick_i), .wdt_o(wdt_osc_i), .osc_cnt_o(osc_cnt), .wdt_cnt_o(wdt_cnt));

    //////////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Classic single cycle; the request holds until ack is sampled high
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (ack_o !== 1'b1) begin
            bad_count++;
            end_sim();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask : wb

    task rst_run(input logic v, input logic [3:0] s, input logic [1:0] t);
        osc_want             <= 8'h00;
        wdt_want             <= 13'h0000;
        fuse_valid_i         <= v;
        clock_select_fuses_i <= s;
        startup_time_fuses_i <= t;
        rst_i                <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : rst_run

    // Lets the far side reach the given edge totals, then lets the sync settle
    task run(input logic [7:0] n, input logic [12:0] m);
        int k;
        osc_want <= n;
        wdt_want <= m;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while ((osc_cnt !== n || wdt_cnt !== m) && k < 20000);
        if (k >= 20000) begin
            bad_count++;
            end_sim();
        end
        repeat (8) @(posedge clk_i);
    endtask : run

    //////////////////////////////////////////////////////////////////////////////
    initial begin
        logic       vld;
        logic [7:0] n;
        logic [2:0] sv;
        logic [1:0] bnd;
        rst_run(1'b0, 4'h0, 2'h0);
        chk({24'h0, sig_addr_o}, 32'h0);
        chk({24'h0, trim_value_o}, 32'h5a);
        wb(1'b0, 4'h0, 32'h0, 4'hf);
        chk(rd, 32'h5a);
        chk({28'h0, use_ext_clk_o, irc_en_o, erc_en_o, band_o}, 32'h08);
        wb(1'b1, 4'h0, 32'hff, 4'hf);
        wb(1'b1, 4'h0, 32'h00, 4'h0);
        wb(1'b0, 4'h0, 32'h0, 4'hf);
        chk(rd, 32'hff);
        chk({24'h0, trim_value_o}, 32'hff);
        wb(1'b0, 4'h2, 32'h0, 4'hf);
        chk(rd, 32'h0);
        $display("Test trim register done");
        // Every select and start-up fuse pair is programmed in turn; fast RC option needs six cycles
        for (int s = 0; s < 16; s++) begin
            for (int t = 0; t < 4; t++) begin
                rst_run(1'b1, 4'(s), 2'(t));
                vld = s <= 8 && !(t == 3 && s <= 4);
                n = (s >= 5 && t != 3) ? 8'd18 : 8'd6;
                sv = vld ? {s == 0, s >= 1 && s <= 4, s >= 5} : 3'b000;
                bnd = sv[1] ? 2'(s - 1) : (sv[0] ? 2'(s - 5) : 2'h0);
                chk({27'h0, use_ext_clk_o, irc_en_o, erc_en_o, band_o},
                    {27'h0, sv, bnd});
                wb(1'b0, 4'h4, 32'h0, 4'hf);
                chk(rd, 32'(t * 16 + s));
                run(n - 8'd1, 13'h0);
                chk({31'h0, core_clk_en_o}, 32'h0);
                run(n, 13'h0);
                chk({31'h0, core_clk_en_o}, {31'h0, vld && t == 0});
                wb(1'b0, 4'h8, 32'h0, 4'hf);
                chk({29'h0, rd[2:0]}, {29'h0, vld && t != 0, !vld, vld && t == 0});
            end
        end
        $display("Test fuse table done");
        rst_run(1'b1, 4'h0, 2'h1);
        // Watchdog edges only count once the cycle count is done
        run(8'd6, 13'd0);
        run(8'd6, 13'd4095);
        chk({31'h0, core_clk_en_o}, 32'h0);
        run(8'd6, 13'd4096);
        chk({31'h0, core_clk_en_o}, 32'h1);
        @(posedge clk_i);
        osc_want <= 8'h00;
        wake_i   <= 1'b1;
        repeat (4) @(posedge clk_i);
        wake_i <= 1'b0;
        chk({31'h0, core_clk_en_o}, 32'h0);
        run(8'd5, 13'd4096);
        chk({31'h0, core_clk_en_o}, 32'h0);
        run(8'd6, 13'd4096);
        chk({31'h0, core_clk_en_o}, 32'h1);
        osc_want <= 8'h00;
        wb(1'b1, 4'hc, 32'h1, 4'hf);
        chk({31'h0, core_clk_en_o}, 32'h0);
        run(8'd6, 13'd4096);
        chk({31'h0, core_clk_en_o}, 32'h1);
        $display("Test watchdog delay and wake done");
        end_sim();
    end
endmodule : clock_source_startup_select_test
